// ---- csc_pkg.sv ----
package csc_pkg;
    // register byte offsets on the apb window
    localparam logic [7:0] OFF_GATE = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_CHMASK = 8'h08;
    localparam logic [7:0] OFF_ACCMASK = 8'h0c;
    localparam logic [7:0] OFF_ACCCNT = 8'h10;
    localparam logic [7:0] OFF_REF = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
    localparam logic [7:0] OFF_RESULT0 = 8'h40;
    localparam logic [7:0] OFF_RESULT_LAST = 8'h78;

    // field positions
    localparam int GATE_BIT = 5;
    localparam int START_BIT = 15;
    localparam int SCAN_HI = 14;
    localparam int SCAN_LO = 13;
    localparam int IE_BIT = 12;
    localparam int SPEED_BIT = 10;
    localparam int AVG_BIT = 7;
    localparam int COUNT_HI = 2;
    localparam int SLEEP_BIT = 7;
    localparam int LOWREF_BIT = 4;
    localparam int HIGHREF_HI = 1;

    // writable bits of each register
    localparam logic [7:0] GATE_WMASK = 8'hbd;
    localparam logic [15:0] CTRL_WMASK = 16'hf400;
    localparam logic [14:0] CHMASK_WMASK = 15'h7fff;
    localparam logic [7:0] ACCCNT_WMASK = 8'h87;
    localparam logic [7:0] REF_WMASK = 8'h93;

    // reset values
    localparam logic [7:0] GATE_RESET = 8'h00;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [14:0] MASK_RESET = 15'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    localparam int NUM_CHANNELS = 15;
    localparam int DATA_W = 12;
    localparam int SUM_W = 16;

    localparam logic [1:0] SCAN_SINGLE = 2'b00;
    localparam logic [1:0] SCAN_CONT = 2'b10;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_REQ = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_STORE = 4'b1000
    } csc_state_t;

    // conversions per channel for a repeat code
    function automatic logic [4:0] csc_repeats(input logic [2:0] code);
        case (code)
            3'b000: csc_repeats = 5'h01;
            3'b001: csc_repeats = 5'h02;
            3'b010: csc_repeats = 5'h03;
            3'b011: csc_repeats = 5'h04;
            3'b101: csc_repeats = 5'h10;
            default: csc_repeats = 5'h01;
        endcase
    endfunction

    // sum divided by the repeat count of the code
    function automatic logic [15:0] csc_average(input logic [15:0] sum,
                                                input logic [2:0] code);
        case (code)
            3'b001: csc_average = sum >> 1;
            3'b010: csc_average = sum / 16'h0003;
            3'b011: csc_average = sum >> 2;
            3'b101: csc_average = sum >> 4;
            default: csc_average = sum;
        endcase
    endfunction
endpackage

// ---- csc_chan_pick.sv ----
`timescale 1ns/1ps
`default_nettype none
// lowest selected channel at or above a start index
module csc_chan_pick #(
    parameter int CHANNELS = 15
) (
    input wire logic [CHANNELS-1:0] mask,
    input wire logic [3:0] from,
    output logic found,
    output logic [3:0] chan
);
    // the channel index is four bits wide
    if (CHANNELS < 1 || CHANNELS > 16) begin : g_bad_channels
        $error("csc_chan_pick: CHANNELS must be 1 to 16");
    end

    always_comb begin
        found = 1'b0;
        chan = 4'h0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (mask[i] && (4'(i) >= from)) begin
                found = 1'b1;
                chan = 4'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ---- csc_accum.sv ----
`timescale 1ns/1ps
`default_nettype none
// running sum of repeated conversions of one channel
module csc_accum #(
    parameter int DW = 12,
    parameter int SW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic add,
    input wire logic [DW-1:0] data,
    output logic [SW-1:0] sum
);
    typedef struct packed {
        logic [SW-1:0] sum;
    } csc_acc_t;

    csc_acc_t r;
    csc_acc_t next_r;

    // sixteen additions need four bits of headroom above the data
    if (SW < DW + 4) begin : g_bad_width
        $error("csc_accum: SW too narrow for sixteen additions");
    end

    always_comb begin
        next_r = r;
        if (clear) begin
            next_r.sum = '0;
        end else if (add) begin
            next_r.sum = r.sum + SW'(data);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sum = r.sum;
endmodule
`default_nettype wire

// ---- csc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module csc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic converter_clk_en,
    output logic conv_req,
    output logic [3:0] conv_channel,
    output logic conv_high_speed,
    input wire logic conv_done,
    input wire logic [csc_pkg::DATA_W-1:0] conv_data,
    output logic converter_sleep_bit,
    output logic low_reference_select,
    output logic [1:0] high_reference_select,
    output logic conversion_done_irq,
    output logic irq
);
    import csc_pkg::*;

    typedef struct packed {
        csc_state_t fsm;
        logic [7:0] gate;
        logic [15:0] ctrl;
        logic [14:0] chmask;
        logic [14:0] accmask;
        logic [7:0] acccnt;
        logic [7:0] refctl;
        logic irq_stat;
        logic irq_mask;
        logic [3:0] chan;
        logic [4:0] reps_left;
        logic [NUM_CHANNELS-1:0][SUM_W-1:0] result;
        logic [31:0] rdata;
        logic rerr;
        logic done_pulse;
    } csc_regs_t;

    csc_regs_t r;
    csc_regs_t next_r;

    logic gate_on;
    logic start;
    logic wr_acc;
    logic [7:0] addr;
    logic pick_found;
    logic [3:0] pick_chan;
    logic [3:0] pick_from;
    logic [SUM_W-1:0] acc_sum;
    logic acc_clear;
    logic acc_add;
    logic scan_end;
    logic [SUM_W-1:0] store_val;
    logic [2:0] rep_code;

    assign gate_on = r.gate[GATE_BIT];
    assign start = r.ctrl[START_BIT];
    assign addr = paddr[7:0];
    assign wr_acc = psel && penable && pwrite;
    assign rep_code = r.acccnt[COUNT_HI:0];
    assign pick_from = (r.fsm == ST_IDLE) ? 4'h0 : 4'(r.chan + 4'h1);

    csc_chan_pick #(
        .CHANNELS(NUM_CHANNELS)
    ) csc_chan_pick_i (
        .mask(r.chmask),
        .from(pick_from),
        .found(pick_found),
        .chan(pick_chan)
    );

    // accumulator is flushed on stop so a restarted scan never sees stale sums
    assign acc_clear = (r.fsm == ST_STORE) || !gate_on || !start;
    assign acc_add = (r.fsm == ST_WAIT) && conv_done;

    csc_accum #(
        .DW(DATA_W),
        .SW(SUM_W)
    ) csc_accum_i (
        .pclk(pclk),
        .presetn(presetn),
        .clear(acc_clear),
        .add(acc_add),
        .data(conv_data),
        .sum(acc_sum)
    );

    always_comb begin
        store_val = acc_sum;
        if (r.accmask[r.chan] && r.acccnt[AVG_BIT]) begin
            store_val = csc_average(acc_sum, rep_code);
        end
    end

    // scan end: last selected channel stored, or nothing selected at all
    assign scan_end = gate_on && start &&
        (((r.fsm == ST_STORE) && !pick_found) ||
         ((r.fsm == ST_IDLE) && !pick_found));

    always_comb begin
        next_r = r;
        next_r.done_pulse = 1'b0;
        case (r.fsm)
            ST_IDLE: begin
                if (start && pick_found) begin
                    next_r.chan = pick_chan;
                    next_r.reps_left = r.accmask[pick_chan] ?
                        5'(csc_repeats(rep_code) - 5'h01) : 5'h00;
                    next_r.fsm = ST_REQ;
                end
            end
            ST_REQ: begin
                next_r.fsm = ST_WAIT;
            end
            ST_WAIT: begin
                if (conv_done) begin
                    if (r.reps_left != 5'h00) begin
                        next_r.reps_left = 5'(r.reps_left - 5'h01);
                        next_r.fsm = ST_REQ;
                    end else begin
                        next_r.fsm = ST_STORE;
                    end
                end
            end
            ST_STORE: begin
                next_r.result[r.chan] = store_val;
                if (pick_found) begin
                    next_r.chan = pick_chan;
                    next_r.reps_left = r.accmask[pick_chan] ?
                        5'(csc_repeats(rep_code) - 5'h01) : 5'h00;
                    next_r.fsm = ST_REQ;
                end else begin
                    next_r.fsm = ST_IDLE;
                end
            end
            default: begin
                next_r.fsm = ST_IDLE;
            end
        endcase
        // continuous scan leaves start set so idle restarts from channel 0
        if (scan_end) begin
            if (r.ctrl[SCAN_HI:SCAN_LO] != SCAN_CONT) begin
                next_r.ctrl[START_BIT] = 1'b0;
            end
            if (r.ctrl[IE_BIT]) begin
                next_r.done_pulse = 1'b1;
                next_r.irq_stat = 1'b1;
            end
        end
        if (!start) begin
            next_r.fsm = ST_IDLE;
        end

        // register writes take effect in the access phase
        if (wr_acc) begin
            if (addr == OFF_GATE) begin
                next_r.gate = pwdata[7:0] & GATE_WMASK;
            end
            if (gate_on) begin
                case (addr)
                    OFF_CTRL: begin
                        next_r.ctrl = pwdata[15:0] & CTRL_WMASK;
                    end
                    OFF_CHMASK: next_r.chmask = pwdata[14:0] & CHMASK_WMASK;
                    OFF_ACCMASK: next_r.accmask = pwdata[14:0] & CHMASK_WMASK;
                    OFF_ACCCNT: next_r.acccnt = pwdata[7:0] & ACCCNT_WMASK;
                    OFF_REF: next_r.refctl = pwdata[7:0] & REF_WMASK;
                    OFF_IRQ_MASK: next_r.irq_mask = pwdata[0];
                    OFF_IRQ_STAT: begin
                        // a scan end in the same cycle wins over the clear
                        next_r.irq_stat = (r.irq_stat && !pwdata[0]) ||
                            (scan_end && r.ctrl[IE_BIT]);
                    end
                    default: begin
                    end
                endcase
                if (addr == OFF_CTRL && pwdata[START_BIT] && !start) begin
                    next_r.fsm = ST_IDLE;
                end
            end
        end

        // read data is captured in the setup phase, so no wait states
        if (psel && !penable) begin
            next_r.rdata = 32'h0000_0000;
            next_r.rerr = 1'b0;
            case (addr)
                OFF_GATE: next_r.rdata = {24'h00_0000, r.gate};
                OFF_CTRL: next_r.rdata = {16'h0000, r.ctrl};
                OFF_CHMASK: next_r.rdata = {17'h0_0000, r.chmask};
                OFF_ACCMASK: next_r.rdata = {17'h0_0000, r.accmask};
                OFF_ACCCNT: next_r.rdata = {24'h00_0000, r.acccnt};
                OFF_REF: next_r.rdata = {24'h00_0000, r.refctl};
                OFF_IRQ_STAT: next_r.rdata = {31'h0, r.irq_stat};
                OFF_IRQ_MASK: next_r.rdata = {31'h0, r.irq_mask};
                default: begin
                    if (addr >= OFF_RESULT0 && addr <= OFF_RESULT_LAST &&
                        addr[1:0] == 2'b00) begin
                        next_r.rdata = {16'h0000,
                            r.result[4'(8'(addr - OFF_RESULT0) >> 2)]};
                    end else begin
                        next_r.rerr = 1'b1;
                    end
                end
            endcase
        end

        // gate low holds every converter register in its reset state
        if (!gate_on) begin
            next_r.fsm = ST_IDLE;
            next_r.ctrl = CTRL_RESET;
            next_r.chmask = MASK_RESET;
            next_r.accmask = MASK_RESET;
            next_r.acccnt = BYTE_RESET;
            next_r.refctl = BYTE_RESET;
            next_r.irq_stat = 1'b0;
            next_r.irq_mask = 1'b0;
            next_r.chan = 4'h0;
            next_r.reps_left = 5'h00;
            next_r.result = '0;
            next_r.done_pulse = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.fsm <= ST_IDLE;
            r.gate <= GATE_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && r.rerr;
    assign converter_clk_en = gate_on;
    assign conv_req = (r.fsm == ST_REQ);
    assign conv_channel = r.chan;
    assign conv_high_speed = !r.ctrl[SPEED_BIT];
    assign converter_sleep_bit = r.refctl[SLEEP_BIT];
    assign low_reference_select = r.refctl[LOWREF_BIT];
    assign high_reference_select = r.refctl[HIGHREF_HI:0];
    assign conversion_done_irq = r.done_pulse;
    assign irq = r.irq_stat && r.irq_mask;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    gate_hold_a: assert property (!gate_on |=> r.ctrl == CTRL_RESET &&
        r.fsm == ST_IDLE && !conv_req)
        else $error("converter not held in reset with gate low");
    gate_clk_a: assert property ($rose(converter_clk_en) |->
        $past(wr_acc) && $past(addr) == OFF_GATE)
        else $error("converter clock started without a gate write");
    start_req_a: assert property (r.fsm == ST_IDLE && gate_on && start &&
        r.chmask != 15'h0000 |=> conv_req)
        else $error("start did not issue a conversion request");
    stop_idle_a: assert property (gate_on && !start |=> r.fsm == ST_IDLE)
        else $error("cleared start did not stop the scan");
    irq_enable_a: assert property (conversion_done_irq |->
        $past(r.ctrl[IE_BIT]) && $past(scan_end))
        else $error("done interrupt without enable or scan end");
    speed_sel_a: assert property (wr_acc && addr == OFF_CTRL && gate_on |=>
        conv_high_speed == !$past(pwdata[SPEED_BIT]))
        else $error("speed select mismatch");
    chan_sel_a: assert property (conv_req |-> r.chmask[conv_channel])
        else $error("request for an unselected channel");
    plain_conv_a: assert property (r.fsm == ST_WAIT && conv_done &&
        !r.accmask[r.chan] && gate_on && start |=> r.fsm == ST_STORE)
        else $error("plain channel converted more than once");
    store_sum_a: assert property (r.fsm == ST_STORE && gate_on && start &&
        !r.acccnt[AVG_BIT] && !wr_acc |=>
        r.result[$past(r.chan)] == $past(acc_sum))
        else $error("summation result not stored");
    single_clear_a: assert property (scan_end &&
        r.ctrl[SCAN_HI:SCAN_LO] == SCAN_SINGLE && !wr_acc |=> !start)
        else $error("single scan left start set");

    scan_done_c: cover property (conversion_done_irq);
    avg_store_c: cover property (r.fsm == ST_STORE && r.accmask[r.chan] &&
        r.acccnt[AVG_BIT] && rep_code == 3'b011);
    cont_restart_c: cover property (scan_end &&
        r.ctrl[SCAN_HI:SCAN_LO] == SCAN_CONT ##[1:4] conv_req);
    stop_mid_c: cover property (r.fsm == ST_WAIT ##1 !start);
endmodule
`default_nettype wire

// ---- csc_front_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// converter front end: answers each request after a short or long delay
module csc_front_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic conv_req,
    input wire logic [3:0] conv_channel,
    input wire logic slow,
    output logic conv_done,
    output logic [11:0] conv_data
);
    logic busy;
    logic [3:0] chan;
    logic [11:0] last;
    int cnt;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            chan <= 4'h0;
            last <= 12'h000;
            cnt <= 0;
            conv_done <= 1'b0;
            conv_data <= 12'h000;
        end else begin
            conv_done <= 1'b0;
            // data is not held outside the done cycle
            conv_data <= ~last;
            if (conv_req) begin
                busy <= 1'b1;
                chan <= conv_channel;
                cnt <= slow ? 6 : 1;
            end else if (busy) begin
                if (cnt == 1) begin
                    busy <= 1'b0;
                    conv_done <= 1'b1;
                    conv_data <= 12'h0a5 + {chan, 8'h00};
                    last <= 12'h0a5 + {chan, 8'h00};
                end else begin
                    cnt <= cnt - 1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- conv_scan_control_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module conv_scan_control_regs_test;
    import csc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic slow = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata;
    logic pready, pslverr, clk_en, conv_req, conv_high_speed, conv_done;
    logic sleep_b, low_ref, done_irq, irq;
    logic [3:0] conv_channel;
    logic [1:0] high_ref;
    logic [11:0] conv_data;
    logic [14:0] chan_seen = 0;
    logic [2:0] codes [5] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b101};
    int err_count = 0, checks_done = 0, req_n = 0, done_n = 0;

    always #20 pclk = ~pclk;

    csc_top csc_top_i(.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .converter_clk_en(clk_en), .conv_req(conv_req),
        .conv_channel(conv_channel), .conv_high_speed(conv_high_speed),
        .conv_done(conv_done), .conv_data(conv_data),
        .converter_sleep_bit(sleep_b), .low_reference_select(low_ref),
        .high_reference_select(high_ref), .conversion_done_irq(done_irq),
        .irq(irq));
    csc_front_model csc_front_model_i(.pclk(pclk), .presetn(presetn),
        .conv_req(conv_req), .conv_channel(conv_channel), .slow(slow),
        .conv_done(conv_done), .conv_data(conv_data));

    always @(posedge pclk) begin
        if (conv_req === 1'b1) begin
            req_n++;
            chan_seen[conv_channel] = 1'b1;
        end
        if (done_irq === 1'b1) done_n++;
    end

    task chk(input string s, input logic [31:0] seen, input logic [31:0] x);
        checks_done++;
        if (seen !== x) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", s, x, seen);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task timeout;
        err_count++;
        $display("mismatch wait expected done seen timeout");
        test_done;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) timeout;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask

    task rdchk(input string s, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        rd(a, q);
        chk(s, q, x);
    endtask

    task wait_idle;
        logic [31:0] v;
        int i;
        for (i = 0; i < 100; i++) begin
            rd(OFF_CTRL, v);
            if (v[15] === 1'b0) break;
        end
        if (i == 100) timeout;
    endtask

    task wait_pulses(input int t);
        int i;
        for (i = 0; i < 600; i++) begin
            if (done_n >= t) break;
            @(posedge pclk);
        end
        if (i == 600) timeout;
    endtask

    task t_gate;
        logic [31:0] q;
        logic e;
        chk("clk_en reset", clk_en, 0);
        wr(OFF_CTRL, 32'h1400);
        rdchk("ctrl gated", OFF_CTRL, 32'h0);
        wr(OFF_GATE, 32'hff);
        rdchk("gate", OFF_GATE, 32'hbd);
        chk("clk_en", clk_en, 1);
        wr(OFF_CTRL, 32'h1400);
        rdchk("ctrl", OFF_CTRL, 32'h1400);
        chk("normal speed", conv_high_speed, 0);
        wr(OFF_CTRL, 32'h1000);
        rdchk("ctrl", OFF_CTRL, 32'h1000);
        chk("high speed", conv_high_speed, 1);
        // unmapped place: error flag, zero data
        apb(1'b0, 8'h30, 32'h0, q, e);
        chk("unmapped data", q, 0);
        chk("unmapped err", e, 1);
        wr(OFF_GATE, 32'h20);
    endtask

    task t_ref;
        logic [31:0] v;
        for (int i = 0; i < 4; i++) begin
            v = {24'h0, i[1], 2'b00, i[0], 2'b00, i[1:0]};
            wr(OFF_REF, v);
            rdchk("ref", OFF_REF, v);
            chk("high ref", high_ref, i[1:0]);
            chk("low ref", low_ref, i[0]);
            chk("sleep", sleep_b, i[1]);
        end
        wr(OFF_REF, 32'hff);
        rdchk("ref mask", OFF_REF, 32'h93);
    endtask

    task scan(input logic [14:0] cm, input logic [14:0] am,
              input logic [7:0] acc, input logic ie, input logic sl);
        int n, e, r0, d0;
        logic [15:0] d;
        n = (acc[2:0] == 3'b101) ? 16 : acc[2:0] + 1;
        slow <= sl;
        wr(OFF_CHMASK, {17'h0, cm});
        wr(OFF_ACCMASK, {17'h0, am});
        wr(OFF_ACCCNT, {24'h0, acc});
        wr(OFF_IRQ_MASK, 32'h1);
        r0 = req_n;
        d0 = done_n;
        chan_seen = 0;
        e = 0;
        wr(OFF_CTRL, ie ? 32'h9000 : 32'h8000);
        wait_idle;
        chk("channels", {17'h0, chan_seen}, {17'h0, cm});
        for (int i = 0; i < 15; i++) begin
            if (cm[i]) begin
                e += am[i] ? n : 1;
                d = 16'h00a5 + 16'(i) * 16'h0100;
                if (am[i] && !acc[7]) d = d * 16'(n);
                rdchk("result", OFF_RESULT0 + 8'(4 * i), {16'h0, d});
            end
        end
        chk("requests", req_n - r0, e);
        chk("done pulses", done_n - d0, ie);
        rdchk("irq status", OFF_IRQ_STAT, ie);
        chk("irq", irq, ie);
        wr(OFF_IRQ_STAT, 32'h1);
        rdchk("status clear", OFF_IRQ_STAT, 0);
    endtask

    task t_irq;
        wr(OFF_IRQ_MASK, 32'h0);
        wr(OFF_CHMASK, 32'h1);
        wr(OFF_CTRL, 32'h9000);
        wait_idle;
        rdchk("status masked", OFF_IRQ_STAT, 1);
        chk("irq masked", irq, 0);
        wr(OFF_IRQ_MASK, 32'h1);
        rdchk("mask", OFF_IRQ_MASK, 1);
        chk("irq unmasked", irq, 1);
        wr(OFF_IRQ_STAT, 32'h1);
        rdchk("status", OFF_IRQ_STAT, 0);
        chk("irq cleared", irq, 0);
    endtask

    task t_cont;
        int r;
        wr(OFF_CHMASK, 32'h2);
        wr(OFF_ACCMASK, 32'h0);
        r = done_n;
        wr(OFF_CTRL, 32'hd000);
        wait_pulses(r + 3);
        rdchk("ctrl running", OFF_CTRL, 32'hd000);
        wr(OFF_CTRL, 32'h0);
        repeat (4) @(posedge pclk);
        r = req_n;
        repeat (30) @(posedge pclk);
        chk("stopped", req_n - r, 0);
        r = done_n;
        wr(OFF_CTRL, 32'hd000);
        wait_pulses(r + 1);
        wr(OFF_GATE, 32'h0);
        rdchk("ctrl held", OFF_CTRL, 0);
        chk("clk off", clk_en, 0);
        r = req_n;
        repeat (30) @(posedge pclk);
        chk("gated", req_n - r, 0);
        wr(OFF_GATE, 32'h20);
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_gate;
        t_ref;
        // every repeat code, sum and average; slow answers for codes 001 and 011, fast for the rest
        for (int k = 0; k < 10; k++) begin
            scan(15'h0009, 15'h0008, {k[0], 4'h0, codes[k / 2]}, 1'b1, k[1]);
        end
        scan(15'h4001, 15'h4001, 8'h85, 1'b0, 1'b1);
        t_irq;
        t_cont;
        test_done;
    end
endmodule
`default_nettype wire
